// ---- hdl/spo_sequencer.sv ----
// spo_sequencer.sv: servo power-on sequencer with AXI4-Lite registers
// assumes synchronous pins; contactor and host keep their own sequence
`include "spo_map.svh"
`default_nettype none
module spo_sequencer
    import spo_pkg::*;
#(
    parameter int ACCEPT_MS = `SPO_ACCEPT_MS,
    parameter int MS_CYC = `SPO_MS_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // axi4-lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power and pins
    input wire logic mainPower,
    input wire logic [31:0] pinIn,
    input wire logic estop_in,
    input wire logic pulse_train_fwd_in,
    input wire logic pulse_train_rev_in,
    // drive outputs
    output logic powerStageOn,
    output logic dynBrake,
    output logic readyOut,
    output logic [7:0] estop_warning_code,
    output logic runFwd,
    output logic runRev,
    output logic pulseFwd,
    output logic pulseRev,
    output logic irq
);
    spo_state_t state_ff, nxt_state;
    logic [31:0] ctrl_ff, map_ff;
    logic [`SPO_IRQ_W-1:0] irqStat_ff, irqMask_ff, irqEvt;
    logic servo_enable_in, fault_clear_in;
    logic timerRestart, timerDone;
    logic [15:0] timerLimit;
    logic speedSel2, fwdRun, revRun, propCtl, tqCap, fwdSel, revSel, pulseEn;
    logic wrFire, rdFire, awHeld_ff, wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic [31:0] maskMerged;

    // pin select by remap field
    function automatic logic pickPin(input logic [31:0] pins, input logic [4:0] idx);
        pickPin = pins[idx];
    endfunction : pickPin

    // byte-enable merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    assign servo_enable_in = pickPin(pinIn, map_ff[`SPO_MAP_SON_LSB +: 5]);
    assign fault_clear_in = pickPin(pinIn, map_ff[`SPO_MAP_RES_LSB +: 5]);

    // one timer shared by acceptance delay and ready delay
    assign timerRestart = (state_ff != nxt_state);
    assign timerLimit = (nxt_state == ST_WAIT) ? 16'(ACCEPT_MS) : 16'(`SPO_READY_MS);

    assign maskMerged = merge({28'h0, irqMask_ff}, wData_ff, wStrb_ff);

    spo_ms_timer #(.MS_CYC(MS_CYC)) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .restart(timerRestart),
        .limit(timerLimit),
        .done(timerDone)
    );

    spo_role_mux u_roles (
        .core_clk(core_clk),
        .rst(rst),
        .mode(ctrl_ff[`SPO_CTRL_MODE_LSB +: `SPO_CTRL_MODE_W]),
        .modeSel(ctrl_ff[`SPO_CTRL_MODE_SEL]),
        .pin16(pinIn[16]),
        .pin17(pinIn[17]),
        .pin18(pinIn[18]),
        .speed_select_bit2(speedSel2),
        .forward_run_in(fwdRun),
        .reverse_run_in(revRun),
        .proportional_ctl_in(propCtl),
        .torque_cap_select_in(tqCap),
        .forward_select_in(fwdSel),
        .reverse_select_in(revSel),
        .pulseEnable(pulseEn)
    );

    // sequencing state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_NOPWR: if (mainPower) nxt_state = ST_WAIT;
            ST_WAIT: if (timerDone) nxt_state = ST_IDLE;
            ST_IDLE: if (servo_enable_in && estop_in && !fault_clear_in) nxt_state = ST_BASE;
            ST_BASE: if (timerDone) nxt_state = ST_READY;
            ST_READY: if (!servo_enable_in) nxt_state = ST_IDLE;
            ST_ESTOP: if (estop_in) nxt_state = ST_IDLE;
            default: nxt_state = ST_NOPWR;
        endcase
        if ((state_ff == ST_BASE || state_ff == ST_READY) && (fault_clear_in || !servo_enable_in)) begin
            nxt_state = ST_IDLE;
        end
        if (!estop_in && state_ff != ST_NOPWR && state_ff != ST_WAIT) begin
            nxt_state = ST_ESTOP;
        end
        if (!mainPower) begin
            nxt_state = ST_NOPWR;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_NOPWR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // drive outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            powerStageOn <= 1'b0;
            readyOut <= 1'b0;
            dynBrake <= 1'b0;
            estop_warning_code <= `SPO_WARN_NOPWR;
        end else begin
            powerStageOn <= (nxt_state == ST_BASE) || (nxt_state == ST_READY);
            readyOut <= (nxt_state == ST_READY);
            dynBrake <= (nxt_state == ST_ESTOP);
            if (nxt_state == ST_NOPWR) begin
                estop_warning_code <= `SPO_WARN_NOPWR;
            end else if (nxt_state == ST_ESTOP) begin
                estop_warning_code <= `SPO_WARN_ESTOP;
            end else begin
                estop_warning_code <= `SPO_WARN_NONE;
            end
        end
    end

    // motion commands pass only while ready, blocked from estop until ready is reached again
    always_ff @(posedge core_clk) begin
        if (rst) begin
            runFwd <= 1'b0;
            runRev <= 1'b0;
            pulseFwd <= 1'b0;
            pulseRev <= 1'b0;
        end else begin
            runFwd <= readyOut && (fwdRun || fwdSel);
            runRev <= readyOut && (revRun || revSel);
            pulseFwd <= readyOut && pulseEn && pulse_train_fwd_in;
            pulseRev <= readyOut && pulseEn && pulse_train_rev_in;
        end
    end

    // interrupt events
    assign irqEvt[`SPO_IRQ_READY] = (nxt_state == ST_READY) && (state_ff != ST_READY);
    assign irqEvt[`SPO_IRQ_ESTOP] = (nxt_state == ST_ESTOP) && (state_ff != ST_ESTOP);
    assign irqEvt[`SPO_IRQ_FCLR] = fault_clear_in && powerStageOn;
    assign irqEvt[`SPO_IRQ_PWRLOSS] = (nxt_state == ST_NOPWR) && (state_ff != ST_NOPWR);

    // axi write: address and data in either order
    assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !awHeld_ff && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHeld_ff && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awAddr_ff)
                    `SPO_OFF_CTRL, `SPO_OFF_IRQ_STAT, `SPO_OFF_IRQ_MASK, `SPO_OFF_MAP: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff <= `SPO_CTRL_RESET;
            map_ff <= `SPO_MAP_RESET;
            irqMask_ff <= '0;
        end else if (wrFire) begin
            case (awAddr_ff)
                `SPO_OFF_CTRL: ctrl_ff <= merge(ctrl_ff, wData_ff, wStrb_ff) & 32'h0000_000F;
                `SPO_OFF_MAP: map_ff <= merge(map_ff, wData_ff, wStrb_ff) & 32'h0000_1F1F;
                `SPO_OFF_IRQ_MASK: irqMask_ff <= maskMerged[`SPO_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStat_ff <= '0;
            irq <= 1'b0;
        end else begin
            if (wrFire && awAddr_ff == `SPO_OFF_IRQ_STAT && wStrb_ff[0]) begin
                irqStat_ff <= (irqStat_ff & ~wData_ff[`SPO_IRQ_W-1:0]) | irqEvt;
            end else begin
                irqStat_ff <= irqStat_ff | irqEvt;
            end
            irq <= |(irqStat_ff & irqMask_ff);
        end
    end

    // axi read
    assign rdFire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (rdFire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `SPO_OFF_CTRL: s_axi_rdata <= ctrl_ff;
                    `SPO_OFF_STATUS: s_axi_rdata <= {16'h0, estop_warning_code, 2'h0, dynBrake,
                                                     readyOut, powerStageOn, 3'(state_ff)};
                    `SPO_OFF_IRQ_STAT: s_axi_rdata <= {28'h0, irqStat_ff};
                    `SPO_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irqMask_ff};
                    `SPO_OFF_MAP: s_axi_rdata <= map_ff;
                    `SPO_OFF_PINS: s_axi_rdata <= {16'h0, 9'h0, speedSel2, propCtl, tqCap, fwdRun, revRun,
                                                   fwdSel, revSel};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : spo_sequencer
`default_nettype wire

// ---- hdl/spo_map.svh ----
// spo_map.svh: register offsets, field positions, reset values and timing counts
// assumes a 100 MHz core clock and 32-bit AXI4-Lite register access
`ifndef SPO_MAP_SVH
`define SPO_MAP_SVH

`define SPO_OFF_CTRL 8'h00
`define SPO_OFF_STATUS 8'h04
`define SPO_OFF_IRQ_STAT 8'h08
`define SPO_OFF_IRQ_MASK 8'h0C
`define SPO_OFF_MAP 8'h10
`define SPO_OFF_PINS 8'h14

// control register fields
`define SPO_CTRL_MODE_LSB 0
`define SPO_CTRL_MODE_W 3
`define SPO_CTRL_MODE_SEL 3
`define SPO_CTRL_RESET 32'h0000_0000

// remap register: 5-bit pin index per function
`define SPO_MAP_SON_LSB 0
`define SPO_MAP_RES_LSB 8
`define SPO_MAP_RESET 32'h0000_0504

// interrupt bits
`define SPO_IRQ_READY 0
`define SPO_IRQ_ESTOP 1
`define SPO_IRQ_FCLR 2
`define SPO_IRQ_PWRLOSS 3
`define SPO_IRQ_W 4

// warning codes
`define SPO_WARN_NONE 8'h00
`define SPO_WARN_NOPWR 8'h01
`define SPO_WARN_ESTOP 8'hE6

// timing
`define SPO_CLK_HZ 100000000
`define SPO_ACCEPT_MS 1500
`define SPO_READY_MS 5
`define SPO_MS_CYC (`SPO_CLK_HZ / 1000)
`define SPO_ACCEPT_CYC (`SPO_ACCEPT_MS * `SPO_MS_CYC)
`define SPO_READY_CYC (`SPO_READY_MS * `SPO_MS_CYC)

`endif

// ---- hdl/spo_pkg.sv ----
// spo_pkg.sv: types for the servo power-on sequencer
// assumes nothing beyond the map header
`default_nettype none
package spo_pkg;
    typedef enum logic [2:0] {
        MODE_POS, MODE_POS_SPD, MODE_SPD, MODE_SPD_TRQ, MODE_TRQ, MODE_TRQ_POS
    } spo_mode_t;
    typedef enum {
        ST_NOPWR, ST_WAIT, ST_IDLE, ST_BASE, ST_READY, ST_ESTOP
    } spo_state_t;
endpackage : spo_pkg
`default_nettype wire

// ---- hdl/spo_ms_timer.sv ----
// spo_ms_timer.sv: counts milliseconds from a 1 ms enable pulse
// assumes a synchronous active-high restart
`include "spo_map.svh"
`default_nettype none
module spo_ms_timer #(
    parameter int MS_CYC = `SPO_MS_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic restart,
    input wire logic [15:0] limit,
    // status
    output logic done
);
    logic [16:0] divCnt_ff;
    logic [15:0] msCnt_ff;
    logic msTick;

    assign msTick = (divCnt_ff == 17'(MS_CYC - 1));

    // ms divider
    always_ff @(posedge core_clk) begin
        if (rst || restart || msTick) begin
            divCnt_ff <= 17'h0_0000;
        end else begin
            divCnt_ff <= divCnt_ff + 17'h0_0001;
        end
    end

    // ms counter, saturates at limit
    always_ff @(posedge core_clk) begin
        if (rst || restart) begin
            msCnt_ff <= 16'h0000;
            done <= 1'b0;
        end else if (msTick && !done) begin
            msCnt_ff <= msCnt_ff + 16'h0001;
            done <= (msCnt_ff + 16'h0001 >= limit);
        end
    end
endmodule : spo_ms_timer
`default_nettype wire

// ---- hdl/spo_role_mux.sv ----
// spo_role_mux.sv: routes connector pins to signal roles by control mode
// assumes pins already synchronous to core_clk
`include "spo_map.svh"
`default_nettype none
module spo_role_mux
    import spo_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // mode
    input wire logic [2:0] mode,
    input wire logic modeSel,
    // pins 16 to 18
    input wire logic pin16,
    input wire logic pin17,
    input wire logic pin18,
    // roles
    output logic speed_select_bit2,
    output logic forward_run_in,
    output logic reverse_run_in,
    output logic proportional_ctl_in,
    output logic torque_cap_select_in,
    output logic forward_select_in,
    output logic reverse_select_in,
    output logic pulseEnable
);
    spo_mode_t m;
    logic second;

    // changeover: modeSel picks the second role of the pair
    assign second = modeSel;

    always_comb begin
        m = spo_mode_t'(mode);
        case (m)
            MODE_POS_SPD: m = second ? MODE_SPD : MODE_POS;
            MODE_SPD_TRQ: m = second ? MODE_TRQ : MODE_SPD;
            MODE_TRQ_POS: m = second ? MODE_POS : MODE_TRQ;
            default: m = spo_mode_t'(mode);
        endcase
    end

    // role assignment per effective mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            speed_select_bit2 <= 1'b0;
            forward_run_in <= 1'b0;
            reverse_run_in <= 1'b0;
            proportional_ctl_in <= 1'b0;
            torque_cap_select_in <= 1'b0;
            forward_select_in <= 1'b0;
            reverse_select_in <= 1'b0;
            pulseEnable <= 1'b0;
        end else begin
            speed_select_bit2 <= (m != MODE_POS) && pin16;
            proportional_ctl_in <= (m == MODE_POS) && pin17;
            torque_cap_select_in <= (m == MODE_POS) && pin18;
            forward_run_in <= (m == MODE_SPD) && pin17;
            reverse_run_in <= (m == MODE_SPD) && pin18;
            reverse_select_in <= (m == MODE_TRQ) && pin17;
            forward_select_in <= (m == MODE_TRQ) && pin18;
            pulseEnable <= (m == MODE_POS);
        end
    end
endmodule : spo_role_mux
`default_nettype wire

// ---- sim/spo_sequencer_properties.sv ----
// spo_sequencer_properties.sv: concurrent checks on the sequencer top ports
// assumes one 100 MHz clock domain and a synchronous active-high reset
`default_nettype none
module spo_sequencer_properties #(
    parameter int ACCEPT_MS = 2,
    parameter int MS_CYC = 100000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // power and pins
    input wire logic mainPower,
    input wire logic [31:0] pinIn,
    input wire logic estop_in,
    // drive outputs
    input wire logic powerStageOn,
    input wire logic dynBrake,
    input wire logic readyOut,
    input wire logic [7:0] estop_warning_code,
    input wire logic runFwd,
    input wire logic runRev,
    input wire logic pulseFwd,
    input wire logic pulseRev
);
    localparam logic [31:0] ACC_MIN = 32'((ACCEPT_MS - 1) * MS_CYC);
    localparam logic [31:0] READY_MIN = 32'(4 * MS_CYC);
    localparam logic [31:0] READY_MAX = 32'(6 * MS_CYC);
    logic [31:0] pwrCnt_ff;
    logic [31:0] stageCnt_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // cycles since main power and since power stage came on
    always_ff @(posedge core_clk) begin
        if (rst || !mainPower) pwrCnt_ff <= 32'h0000_0000;
        else if (pwrCnt_ff != 32'hFFFF_FFFF) pwrCnt_ff <= pwrCnt_ff + 32'h0000_0001;
    end
    always_ff @(posedge core_clk) begin
        if (rst || !powerStageOn) stageCnt_ff <= 32'h0000_0000;
        else if (stageCnt_ff != 32'hFFFF_FFFF) stageCnt_ff <= stageCnt_ff + 32'h0000_0001;
    end

    chk_accept_delay: assert property ($rose(powerStageOn) |-> pwrCnt_ff >= ACC_MIN)
        else $error("power stage enabled before acceptance delay");
    chk_ready_delay: assert property ($rose(readyOut) |-> stageCnt_ff >= READY_MIN && stageCnt_ff <= READY_MAX)
        else $error("ready not about 5 ms after power stage");
    chk_nopwr_warn: assert property (!mainPower [*3] |-> estop_warning_code == 8'h01 && !powerStageOn && !readyOut)
        else $error("no power warning or outputs wrong");
    chk_pwr_warn_clear: assert property ($rose(mainPower) ##1 (mainPower && estop_in) [*3] |-> estop_warning_code == 8'h00)
        else $error("power warning not cleared");
    chk_estop_brake: assert property ($fell(estop_in) && mainPower |-> ##[1:2] (dynBrake && estop_warning_code == 8'hE6 && !powerStageOn))
        else $error("emergency stop did not brake");
    chk_clear_coast: assert property ($rose(pinIn[19]) |-> ##[1:2] (!powerStageOn && !dynBrake))
        else $error("fault clear did not free the shaft");
    chk_brake_stage: assert property (dynBrake |-> !powerStageOn && !readyOut)
        else $error("brake while power stage on");
    chk_run_gated: assert property ((runFwd || runRev || pulseFwd || pulseRev) |-> $past(readyOut))
        else $error("command passed while not ready");

    cover property ($rose(readyOut));
    cover property ($fell(estop_in) && mainPower);
    cover property ($rose(pinIn[19]) && powerStageOn);
endmodule : spo_sequencer_properties
`default_nettype wire

// ---- sim/spo_host_model.sv ----
// spo_host_model.sv: host controller and contactor sequence around the drive
// assumes bench commands change just after a rising edge
`default_nettype none
module spo_host_model #(
    parameter int TRIP_DLY = 20
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench commands
    input wire logic cmdPower,
    input wire logic cmdServo,
    input wire logic cmdClear,
    input wire logic cmdStop,
    input wire logic cmdRun,
    // drive side
    output logic mainPower,
    output logic [31:0] pinIn,
    output logic estop_in,
    output logic pulse_train_fwd_in,
    output logic pulse_train_rev_in
);
    logic [7:0] tripCnt_ff;
    logic runOk;
    assign runOk = cmdRun && !cmdStop;
    // contactor drop delay after stop
    always_ff @(posedge core_clk) begin
        if (rst) tripCnt_ff <= 8'h00;
        else if (cmdStop && tripCnt_ff != 8'hFF) tripCnt_ff <= tripCnt_ff + 8'h01;
    end
    // main power only once control side is out of reset
    always_ff @(posedge core_clk) begin
        if (rst) mainPower <= 1'b0;
        else mainPower <= cmdPower && (tripCnt_ff < 8'(TRIP_DLY));
    end
    // single stop, never toggled for run control
    always_ff @(posedge core_clk) begin
        estop_in <= rst || !cmdStop;
        pinIn <= rst ? 32'h0000_0000 : {12'h000, cmdClear, 1'b0, runOk, 1'b0, cmdServo, 15'h0000};
        pulse_train_fwd_in <= !rst && runOk;
        pulse_train_rev_in <= 1'b0;
    end
endmodule : spo_host_model
`default_nettype wire

// ---- sim/spo_sequencer_tb.sv ----
// spo_sequencer_tb.sv: register and power sequence tests of the sequencer
// assumes the host model drives power and pins; acceptance shortened to 2 ms
`include "spo_map.svh"
`default_nettype none
module spo_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACC = 2;
    localparam int MSC = 100;
    logic core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, estop_warning_code;
    logic [31:0] s_axi_wdata, s_axi_rdata, pinIn, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, e;
    logic mainPower, estop_in, pulse_train_fwd_in, pulse_train_rev_in, irq;
    logic powerStageOn, dynBrake, readyOut, runFwd, runRev, pulseFwd, pulseRev;
    logic cmdPower, cmdServo, cmdClear, cmdStop, cmdRun;
    int miscompares, n_compared, n;

    spo_sequencer #(.ACCEPT_MS(ACC), .MS_CYC(MSC)) u_spo_sequencer (.core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mainPower(mainPower), .pinIn(pinIn),
        .estop_in(estop_in), .pulse_train_fwd_in(pulse_train_fwd_in), .pulse_train_rev_in(pulse_train_rev_in),
        .powerStageOn(powerStageOn), .dynBrake(dynBrake), .readyOut(readyOut),
        .estop_warning_code(estop_warning_code), .runFwd(runFwd), .runRev(runRev), .pulseFwd(pulseFwd),
        .pulseRev(pulseRev), .irq(irq));
    spo_host_model u_spo_host_model (.core_clk(core_clk), .rst(rst), .cmdPower(cmdPower), .cmdServo(cmdServo),
        .cmdClear(cmdClear), .cmdStop(cmdStop), .cmdRun(cmdRun), .mainPower(mainPower), .pinIn(pinIn),
        .estop_in(estop_in), .pulse_train_fwd_in(pulse_train_fwd_in), .pulse_train_rev_in(pulse_train_rev_in));

    task automatic test_done;
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic timed_out(input string what);
        miscompares++;
        $display("mismatch %s expected done seen timeout", what);
        test_done();
    endtask : timed_out
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 100) timed_out("write");
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 100) timed_out("read");
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // sel 0 waits on power stage, 1 on ready
    task automatic wait_sig(input int sel, input logic want, input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge core_clk);
            if ((sel == 0 ? powerStageOn : readyOut) === want) break;
        end
        if (n == lim) timed_out("wait");
    endtask : wait_sig

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
        {cmdPower, cmdServo, cmdClear, cmdStop, cmdRun} = 5'h00;
        miscompares = 0;
        n_compared = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check("warning code", 32'h01, estop_warning_code);
        axi_read(`SPO_OFF_CTRL);
        check("ctrl reset", `SPO_CTRL_RESET, rd);
        axi_read(`SPO_OFF_MAP);
        check("map reset", `SPO_MAP_RESET, rd);
        axi_read(8'h20);
        check("unmapped rresp", 32'h2, rsp);
        check("unmapped rdata", 32'h0, rd);
        axi_write(`SPO_OFF_STATUS, 32'hFFFF_FFFF);
        check("status bresp", 32'h2, rsp);
        axi_write(`SPO_OFF_MAP, 32'h0000_130F);
        axi_read(`SPO_OFF_MAP);
        check("map", 32'h0000_130F, rd);
        axi_write(`SPO_OFF_IRQ_MASK, 32'h0);
        cmdServo <= 1'b1;
        cmdPower <= 1'b1;
        repeat (100) @(posedge core_clk);
        check("stage early", 32'h0, powerStageOn);
        check("warning cleared", 32'h00, estop_warning_code);
        wait_sig(0, 1'b1, 4 * MSC);
        check("accept time", 32'h1, 32'(n + 100 >= (ACC - 1) * MSC));
        wait_sig(1, 1'b1, 7 * MSC);
        check("ready time", 32'h1, 32'(n >= 4 * MSC));
        axi_read(`SPO_OFF_IRQ_STAT);
        check("ready event", 32'h1, rd);
        check("irq masked", 32'h0, irq);
        axi_write(`SPO_OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge core_clk);
        check("irq raised", 32'h1, irq);
        axi_write(`SPO_OFF_IRQ_STAT, 32'h1);
        repeat (3) @(posedge core_clk);
        check("irq cleared", 32'h0, irq);
        cmdRun <= 1'b1;
        for (int m = 0; m < 6; m++) begin
            for (int s = 0; s < 2; s++) begin
                e = {(m == 2) || (m == 1 && s == 1) || (m == 3 && s == 0), (m == 0) || (m == 1 && s == 0) || (m == 5 && s == 1)};
                axi_write(`SPO_OFF_CTRL, 32'(m + s * 8));
                repeat (4) @(posedge core_clk);
                check("run fwd", 32'(e[1]), runFwd);
                check("pulse fwd", 32'(e[0]), pulseFwd);
            end
        end
        cmdRun <= 1'b0;
        cmdClear <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("clear stage", 32'h0, {dynBrake, readyOut, powerStageOn});
        cmdClear <= 1'b0;
        wait_sig(0, 1'b1, 50);
        cmdStop <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("estop brake", 32'h2, {dynBrake, powerStageOn});
        check("estop code", 32'hE6, estop_warning_code);
        repeat (40) @(posedge core_clk);
        check("power off code", 32'h01, estop_warning_code);
        check("power off stage", 32'h0, powerStageOn);
        axi_read(`SPO_OFF_IRQ_STAT);
        check("event bits", 32'hE, rd);
        test_done();
    end
endmodule : spo_sequencer_tb

bind spo_sequencer spo_sequencer_properties #(.ACCEPT_MS(ACCEPT_MS), .MS_CYC(MS_CYC)) u_spo_sequencer_properties (
    .core_clk(core_clk), .rst(rst), .mainPower(mainPower), .pinIn(pinIn), .estop_in(estop_in),
    .powerStageOn(powerStageOn), .dynBrake(dynBrake), .readyOut(readyOut),
    .estop_warning_code(estop_warning_code), .runFwd(runFwd), .runRev(runRev), .pulseFwd(pulseFwd),
    .pulseRev(pulseRev));
`default_nettype wire
